// ### bench/baseband_ctrl.sv
`timescale 1ns/10ps
module baseband_ctrl #(parameter GAIN_9DB = 2'h1) (
   // Clock and read data
   input wire clk,
   input wire [13:0] rdata,
   // Mode pins
   output reg power_down_n,
   output reg tx_rx_select,
   // Register port
   output reg wr,
   output reg rd,
   output reg [3:0] addr,
   output reg [13:0] wdata
);
   initial {power_down_n, tx_rx_select, wr, rd, addr, wdata} = 22'h0;
   task pins(input p, s);
      @(posedge clk) {power_down_n, tx_rx_select} <= {p, s};
   endtask
   task wreg(input [3:0] a, input [13:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'h1, a, d};
      @(posedge clk) wr <= 1'h0;
   endtask
   task rreg(input [3:0] a, output [13:0] d);
      @(posedge clk) {rd, addr} <= {1'h1, a};
      @(posedge clk) rd <= 1'h0;
      #1 d = rdata;
   endtask
   task boot;
      wreg(4'h0, 14'h0);
      wreg(4'h5, {1'h0, GAIN_9DB, 11'h0});
   endtask
   // Gain before the cal bit; both pins then go high to enter Tx cal
   task tx_cal_entry;
      wreg(4'h5, {1'h0, GAIN_9DB, 11'h0});
      wreg(4'h6, 14'h0002);
      pins(1'h1, 1'h1);
   endtask
endmodule

// ### bench/mode_ctrl_sva.sv
`timescale 1ns/10ps
module mode_ctrl_sva (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire rd,
   input wire [13:0] rdata,
   // Watched enables
   input wire synth_en,
   input wire rx_path_en,
   input wire lna_en,
   input wire tx_path_en,
   input wire pa_en,
   input wire am_detector_en,
   input wire rx_iq_buf_en,
   input wire rx_mux_detector,
   input wire tx_loopback_en,
   input wire [2:0] mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_sd; mode == 3'h0 |-> !(synth_en | rx_path_en | tx_path_en); endproperty
   a_sd: assert property (p_sd) else $error("shutdown on");
   property p_sb; mode == 3'h1 |-> synth_en && !(rx_path_en | tx_path_en); endproperty
   a_sb: assert property (p_sb) else $error("standby");
   property p_rx; mode == 3'h2 |-> rx_path_en && lna_en && !tx_path_en; endproperty
   a_rx: assert property (p_rx) else $error("rx");
   property p_tx; mode == 3'h3 |-> tx_path_en && pa_en && !rx_path_en; endproperty
   a_tx: assert property (p_tx) else $error("tx");
   property p_tc; mode == 3'h5 |-> !pa_en && am_detector_en && rx_iq_buf_en; endproperty
   a_tc: assert property (p_tc) else $error("tx cal");
   property p_mx; mode != 3'h7 |-> rx_mux_detector == (mode == 3'h5); endproperty
   a_mx: assert property (p_mx) else $error("mux");
   property p_rc; mode == 3'h4 |-> tx_loopback_en && synth_en && !lna_en; endproperty
   a_rc: assert property (p_rc) else $error("rx cal");
   property p_rd; rdata != 14'h0 |-> $past(rd); endproperty
   a_rd: assert property (p_rd) else $error("rdata");
endmodule
bind transceiver_mode_control mode_ctrl_sva chk_u (.*);

// ### bench/transceiver_mode_control_test.sv
`timescale 1ns/10ps
module transceiver_mode_control_test;
   reg clk = 1'h0, rst = 1'h1;
   wire power_down_n, tx_rx_select, wr, rd, synth_en, rx_path_en, lna_en, tx_path_en, pa_en;
   wire upconv_en, cal_tone_en, am_detector_en, rx_iq_buf_en, rx_mux_detector, tx_loopback_en;
   wire [3:0] addr;
   wire [13:0] wdata, rdata;
   wire [2:0] mode;
   wire [1:0] detector_gain_field;
   integer bad_count = 0, checked = 0, i;
   reg [13:0] got;
   reg [6:0] e;
   reg [10:0] en_e;
   transceiver_mode_control dut_u (.*);
   baseband_ctrl ctl_u (.*);
   initial forever #5 clk = ~clk;
   task chk(input [13:0] x, a, input string w);
      checked = checked + 1;
      if (a !== x) begin
         bad_count = bad_count + 1;
         $display("wrong value %0s exp %0h got %0h", w, x, a);
      end
   endtask
   task give_verdict;
      $display("checks %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Writes land while shut down, so the register file must stay awake
   task t_shut;
      ctl_u.boot;
      ctl_u.rreg(4'h5, got);
      chk({1'h0, ctl_u.GAIN_9DB, 11'h0}, got, "reg5");
      chk(ctl_u.GAIN_9DB, detector_gain_field, "gain");
      chk(14'h0, mode, "mode");
      $display("t_shut done");
   endtask
   // Pins and cal bits per row: {pdn, sel, cal, mode}
   task t_modes;
      for (i = 0; i < 6; i = i + 1) begin
         e = {7'h00, 7'h21, 7'h52, 7'h6B, 7'h4C, 7'h75} >> (7 * (5 - i));
         ctl_u.wreg(4'h6, {12'h0, e[4:3]});
         ctl_u.pins(e[6], e[5]);
         repeat (8) @(posedge clk);
         #1 chk(e[2:0], mode, "mode");
         en_e = {11'h000, 11'h400, 11'h704, 11'h4E0, 11'h635, 11'h4AE} >> (11 * (5 - i));
         chk(en_e, {synth_en, rx_path_en, lna_en, tx_path_en, pa_en, upconv_en, cal_tone_en,
            am_detector_en, rx_iq_buf_en, rx_mux_detector, tx_loopback_en}, "enables");
         ctl_u.rreg(4'hF, got);
         chk({9'h000, e[6:5], e[2:0]}, got, "status");
      end
      $display("t_modes done");
   endtask
   // Calibration entry as the controller sequences it
   task t_txcal;
      ctl_u.pins(1'h0, 1'h0);
      repeat (8) @(posedge clk);
      ctl_u.tx_cal_entry;
      repeat (8) @(posedge clk);
      #1 chk(14'h0005, mode, "cal mode");
      chk(ctl_u.GAIN_9DB, detector_gain_field, "cal gain");
      chk(1'h1, rx_mux_detector, "cal mux");
      $display("t_txcal done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      t_shut;
      t_modes;
      t_txcal;
      give_verdict;
   end
   initial begin
      #20000;
      bad_count = bad_count + 1;
      give_verdict;
   end
endmodule

// ### inc/mode_ctrl_defines.vh
`ifndef MODE_CTRL_DEFINES_VH
`define MODE_CTRL_DEFINES_VH

// ---------------------------------------------
// Register port
// ---------------------------------------------
`define ADDR_W 4
`define DATA_W 14
`define REG_MODE_ADDR 4'h6
`define REG_DET_ADDR 4'h5
`define REG_STATUS_ADDR 4'hF
`define REG_COUNT 16
`define REG0_DEFAULT 14'h0000

// ---------------------------------------------
// Fields
// ---------------------------------------------
`define CAL_RX_BIT 0
`define CAL_TX_BIT 1
`define DET_GAIN_HI 12
`define DET_GAIN_LO 11

// ---------------------------------------------
// Mode codes
// ---------------------------------------------
`define MODE_SHUTDOWN 3'h0
`define MODE_STANDBY 3'h1
`define MODE_RX 3'h2
`define MODE_TX 3'h3
`define MODE_RX_CAL 3'h4
`define MODE_TX_CAL 3'h5

`endif

// ### logic/transceiver_mode_control.v
`timescale 1ns/10ps
`include "mode_ctrl_defines.vh"

// Function
// [R1] Both pins low: shutdown, only registers alive
// [R2] Shutdown still accepts and keeps register writes
// [R3] Controller writes default into register 0
// [R4] Standby: synthesizer, oscillator, LO generation on
// [R5] Power up, select low: receive path on
// [R6] Both pins high: transmit path on
// [R7] Tx cal: Tx on except PA, detector on
// [R8] Tx cal: detector routed to Rx I/Q
// [R9] Controller sets detector gain before Tx cal
// [R10] Controller drives tone and trims offsets
// [R11] Rx cal: loopback, synth on, LNA off
// [R12] Receive plus low cal bit: Rx cal
// [R13] Transmit plus high cal bit: Tx cal
// [R14] Decode follows pins and bits continuously
module transceiver_mode_control (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Mode pins
   input wire power_down_n,
   input wire tx_rx_select,
   // Register port
   input wire [`ADDR_W-1:0] addr,
   input wire [`DATA_W-1:0] wdata,
   input wire wr,
   input wire rd,
   output reg [`DATA_W-1:0] rdata,
   // Circuit group enables
   output reg synth_en,
   output reg rx_path_en,
   output reg lna_en,
   output reg tx_path_en,
   output reg pa_en,
   output reg upconv_en,
   output reg cal_tone_en,
   output reg am_detector_en,
   output reg rx_iq_buf_en,
   output reg rx_mux_detector,
   output reg tx_loopback_en,
   output reg [2:0] mode,
   output reg [1:0] detector_gain_field
);

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   reg [2:0] pdn_sync_r;
   reg [2:0] sel_sync_r;
   reg pdn_r;
   reg sel_r;

   // A change counts only when stages two and three agree
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pdn_sync_r <= 3'h0;
         sel_sync_r <= 3'h0;
         pdn_r <= 1'b0;
         sel_r <= 1'b0;
      end else begin
         pdn_sync_r <= {pdn_sync_r[1:0], power_down_n};
         sel_sync_r <= {sel_sync_r[1:0], tx_rx_select};
         if (pdn_sync_r[1] == pdn_sync_r[2])
            pdn_r <= pdn_sync_r[2];
         if (sel_sync_r[1] == sel_sync_r[2])
            sel_r <= sel_sync_r[2];
      end
   end

   // ---------------------------------------------
   // Register file
   // ---------------------------------------------
   // Storage is never gated by mode, so shutdown keeps contents
   // Register 0 resets to its default so shutdown current stays low
   reg [`DATA_W-1:0] regs_r [0:`REG_COUNT-1];
   integer i;
   // Status address is refused so software cannot fake the pin state
   wire write_ok = wr && (addr != `REG_STATUS_ADDR);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `REG_COUNT; i = i + 1)
            regs_r[i] <= `REG0_DEFAULT;
      end else if (write_ok) begin
         regs_r[addr] <= wdata; // [R2]
      end
   end

   // Status is read-only; filtered pins show what the decode really saw
   function [`DATA_W-1:0] status_word;
      input pdn_bit;
      input sel_bit;
      input [2:0] mode_code;
      begin
         status_word = {{(`DATA_W-5){1'b0}}, pdn_bit, sel_bit, mode_code};
      end
   endfunction

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= {`DATA_W{1'b0}};
      end else if (rd) begin
         if (addr == `REG_STATUS_ADDR)
            rdata <= status_word(pdn_r, sel_r, mode);
         else
            rdata <= regs_r[addr];
      end else begin
         // Zero outside the answer cycle so a stale word is never taken
         rdata <= {`DATA_W{1'b0}};
      end
   end

   // ---------------------------------------------
   // Mode decode
   // ---------------------------------------------
   wire [`DATA_W-1:0] mode_reg = regs_r[`REG_MODE_ADDR];
   wire [`DATA_W-1:0] det_reg = regs_r[`REG_DET_ADDR];
   reg [2:0] mode_nxt;

   // Pure decode of current inputs, no command needed to apply
   // Cal bits are ignored in shutdown and standby
   always @* begin // [R14]
      case ({pdn_r, sel_r})
         2'b00: mode_nxt = `MODE_SHUTDOWN; // [R1]
         2'b01: mode_nxt = `MODE_STANDBY; // [R4]
         2'b10: begin
            if (mode_reg[`CAL_RX_BIT])
               mode_nxt = `MODE_RX_CAL; // [R12]
            else
               mode_nxt = `MODE_RX; // [R5]
         end
         2'b11: begin
            if (mode_reg[`CAL_TX_BIT])
               mode_nxt = `MODE_TX_CAL; // [R13]
            else
               mode_nxt = `MODE_TX; // [R6]
         end
         default: mode_nxt = `MODE_SHUTDOWN;
      endcase
   end

   // ---------------------------------------------
   // Circuit group enables
   // ---------------------------------------------
   // One row per mode keeps the table readable; unused groups stay off
   reg synth_nxt;
   reg rx_path_nxt;
   reg lna_nxt;
   reg tx_path_nxt;
   reg pa_nxt;
   reg upconv_nxt;
   reg cal_tone_nxt;
   reg am_detector_nxt;
   reg rx_iq_buf_nxt;
   reg rx_mux_nxt;
   reg loopback_nxt;

   always @* begin
      case (mode_nxt)
         `MODE_SHUTDOWN: begin
            synth_nxt = 1'b0; // [R1]
            rx_path_nxt = 1'b0; // [R1]
            lna_nxt = 1'b0;
            tx_path_nxt = 1'b0; // [R1]
            pa_nxt = 1'b0;
            upconv_nxt = 1'b0;
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b0;
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b0;
         end
         `MODE_STANDBY: begin
            synth_nxt = 1'b1; // [R4]
            rx_path_nxt = 1'b0; // [R4]
            lna_nxt = 1'b0;
            tx_path_nxt = 1'b0; // [R4]
            pa_nxt = 1'b0;
            upconv_nxt = 1'b0;
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b0;
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b0;
         end
         `MODE_RX: begin
            synth_nxt = 1'b1;
            rx_path_nxt = 1'b1; // [R5]
            lna_nxt = 1'b1; // [R5]
            tx_path_nxt = 1'b0;
            pa_nxt = 1'b0;
            upconv_nxt = 1'b0;
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b1; // [R5]
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b0;
         end
         `MODE_TX: begin
            synth_nxt = 1'b1;
            rx_path_nxt = 1'b0;
            lna_nxt = 1'b0;
            tx_path_nxt = 1'b1; // [R6]
            pa_nxt = 1'b1; // [R6]
            upconv_nxt = 1'b1; // [R6]
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b0;
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b0;
         end
         `MODE_RX_CAL: begin
            synth_nxt = 1'b1; // [R11]
            rx_path_nxt = 1'b1;
            lna_nxt = 1'b0; // [R11]
            tx_path_nxt = 1'b0;
            pa_nxt = 1'b0;
            upconv_nxt = 1'b1;
            cal_tone_nxt = 1'b1;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b1;
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b1; // [R11]
         end
         `MODE_TX_CAL: begin
            synth_nxt = 1'b1;
            rx_path_nxt = 1'b0;
            lna_nxt = 1'b0;
            tx_path_nxt = 1'b1; // [R7]
            pa_nxt = 1'b0; // [R7]
            upconv_nxt = 1'b1; // [R7]
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b1; // [R7]
            rx_iq_buf_nxt = 1'b1; // [R7]
            rx_mux_nxt = 1'b1; // [R8]
            loopback_nxt = 1'b0;
         end
         // Unused codes fall back to all groups off
         default: begin
            synth_nxt = 1'b0;
            rx_path_nxt = 1'b0;
            lna_nxt = 1'b0;
            tx_path_nxt = 1'b0;
            pa_nxt = 1'b0;
            upconv_nxt = 1'b0;
            cal_tone_nxt = 1'b0;
            am_detector_nxt = 1'b0;
            rx_iq_buf_nxt = 1'b0;
            rx_mux_nxt = 1'b0;
            loopback_nxt = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------
   // Enable registers
   // ---------------------------------------------
   // Registered so enables never glitch during a pin change
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mode <= `MODE_SHUTDOWN;
         synth_en <= 1'b0;
         rx_path_en <= 1'b0;
         lna_en <= 1'b0;
         tx_path_en <= 1'b0;
         pa_en <= 1'b0;
         upconv_en <= 1'b0;
         cal_tone_en <= 1'b0;
         am_detector_en <= 1'b0;
         rx_iq_buf_en <= 1'b0;
         rx_mux_detector <= 1'b0;
         tx_loopback_en <= 1'b0;
      end else begin
         mode <= mode_nxt;
         synth_en <= synth_nxt;
         rx_path_en <= rx_path_nxt;
         lna_en <= lna_nxt;
         tx_path_en <= tx_path_nxt;
         pa_en <= pa_nxt;
         upconv_en <= upconv_nxt;
         cal_tone_en <= cal_tone_nxt;
         am_detector_en <= am_detector_nxt;
         rx_iq_buf_en <= rx_iq_buf_nxt;
         rx_mux_detector <= rx_mux_nxt;
         tx_loopback_en <= loopback_nxt;
      end
   end

   // Gain field is mirrored in every mode so the detector is ready early
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         detector_gain_field <= 2'h0;
      end else begin
         detector_gain_field <= det_reg[`DET_GAIN_HI:`DET_GAIN_LO];
      end
   end

endmodule
